// ### rtl/asu_pkg.sv
// constants, field layouts and carrier types of the async serial unit
// assumes an APB master on one 100 MHz clock; line pins synchronous to it
package asu_pkg;

  // ==========================================================
  // register map
  localparam logic [7:0]  OFF_CFG    = 8'h00;
  localparam logic [7:0]  OFF_CTRL   = 8'h04;
  localparam logic [7:0]  OFF_STAT1  = 8'h08;
  localparam logic [7:0]  OFF_STAT2  = 8'h0c;
  localparam logic [7:0]  OFF_DATA   = 8'h10;
  localparam logic [7:0]  OFF_BAUD   = 8'h14;
  localparam int          RX9_POS    = 15;
  localparam int          TX9_POS    = 14;
  localparam int          RAF_POS    = 0;
  localparam int          SBK_POS    = 0;

  // ==========================================================
  // reset values
  localparam logic [12:0] BAUD_RST   = 13'h0033;
  localparam logic [7:0]  CTRL_RST   = 8'h00;
  localparam logic [3:0]  CFG_RST    = 4'h0;
  localparam logic [7:0]  STAT_RST   = 8'hc0;

  // ==========================================================
  // framing and 16x oversampling
  localparam logic [3:0]  FLEN_8     = 4'ha;
  localparam logic [3:0]  FLEN_9     = 4'hb;
  localparam logic [3:0]  PH_S1      = 4'h7;
  localparam logic [3:0]  PH_S2      = 4'h8;
  localparam logic [3:0]  PH_S3      = 4'h9;
  localparam logic [3:0]  PH_LAST    = 4'hf;

  typedef struct packed {
    logic tx_empty_irq_enable;
    logic tx_done_irq_enable;
    logic rx_irq_enable;
    logic quiet_line_irq_enable;
    logic tx_enable;
    logic rx_enable;
    logic rx_wakeup_sleep;
    logic break_send;
  } asu_ctrl_s;

  typedef struct packed {
    logic nine_bit;
    logic parity_en;
    logic parity_odd;
    logic wake_by_addr;
  } asu_cfg_s;

  typedef struct packed {
    logic tx_buffer_empty_flag;
    logic tx_complete_flag;
    logic rx_full_flag;
    logic idle_line_flag;
    logic overrun_flag;
    logic noise_flag;
    logic framing_error_flag;
    logic parity_error_flag;
  } asu_stat_s;

  typedef enum logic {TX_IDLE, TX_SHIFT} asu_tx_e;
  typedef enum logic {RX_IDLE, RX_FRAME} asu_rx_e;

endpackage

// ### rtl/asu_serial.sv
// async serial unit: control, status, data port, transmitter, receiver
// assumes APB master on pclk; rxd is already synchronous to pclk
//
// Design decisions made here: the address map and the APB register port.
`timescale 1ns/10ps
module asu_serial (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rxd,
  output logic             txd,
  output logic             irq
);

  // ==========================================================
  // functions
  function automatic logic calc_par(input logic [8:0] d, input logic nine,
                                    input logic odd);
    calc_par = odd ^ (nine ? (^d[7:0]) : (^d[6:0]));
  endfunction

  function automatic logic [3:0] frame_len(input logic nine);
    frame_len = nine ? asu_pkg::FLEN_9 : asu_pkg::FLEN_8;
  endfunction

  // ==========================================================
  // declarations
  asu_pkg::asu_ctrl_s ctrl_r;
  asu_pkg::asu_cfg_s  cfg_r;
  asu_pkg::asu_stat_s stat_r;
  logic [7:0]         armed_r;
  logic [7:0]         set_vec;
  logic [7:0]         clr_vec;
  logic [12:0]        baud_r;
  logic [12:0]        baud_cnt_r;
  logic               tick;
  logic               acc;
  logic               wr;
  logic               rd;
  logic               hit;
  logic               stat_rd;
  logic               data_rd;
  logic               data_wr;
  logic               ctrl_wr;
  logic [3:0]         flen;
  // transmitter
  asu_pkg::asu_tx_e   tx_state_r;
  logic [10:0]        tx_sh_r;
  logic [3:0]         tx_cnt_r;
  logic [3:0]         tx_ph_r;
  logic [7:0]         tx_buf_r;
  logic               tx9_r;
  logic               tx_full_r;
  logic               pre_pend_r;
  logic               brk_pend_r;
  logic               te_prev_r;
  logic               tx_bound;
  logic               tx_free;
  logic               ld_brk;
  logic               ld_pre;
  logic               ld_dat;
  logic               tx_done;
  logic [8:0]         tx_word;
  // receiver
  asu_pkg::asu_rx_e   rx_state_r;
  logic [3:0]         rx_ph_r;
  logic [3:0]         rx_idx_r;
  logic [8:0]         rx_sh_r;
  logic [7:0]         rx_buf_r;
  logic               rx9_r;
  logic               s1_r;
  logic               s2_r;
  logic               noisy_r;
  logic               rxd_prev_r;
  logic [3:0]         idle_cnt_r;
  logic               msg_seen_r;
  logic               bitval;
  logic               bit_noisy;
  logic               rx_fin;
  logic               rx_msb;
  logic               idle_det;
  logic               wake;
  logic               take_char;
  logic               rx_full_flag_ev;
  logic               ovr_ev;

  // ==========================================================
  // baud tick: 16 ticks per bit, divisor writable
  assign tick = (baud_cnt_r == 13'h0000);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      baud_cnt_r <= 13'h0000;
    end else if (tick) begin
      baud_cnt_r <= baud_r;
    end else begin
      baud_cnt_r <= baud_cnt_r - 13'h0001;
    end
  end

  // ==========================================================
  // APB slave, zero wait states
  assign acc     = psel & penable;
  assign wr      = acc & pwrite;
  assign rd      = acc & ~pwrite;
  assign pready  = 1'b1;
  assign pslverr = acc & ~hit;
  assign stat_rd = rd & (paddr == asu_pkg::OFF_STAT1);
  assign data_rd = rd & (paddr == asu_pkg::OFF_DATA);
  assign data_wr = wr & (paddr == asu_pkg::OFF_DATA);
  assign ctrl_wr = wr & (paddr == asu_pkg::OFF_CTRL);
  assign flen    = frame_len(cfg_r.nine_bit);

  always_comb begin
    hit    = 1'b1;
    prdata = 32'h0000_0000;
    if (paddr == asu_pkg::OFF_CFG) begin
      prdata = 32'(cfg_r);
    end else if (paddr == asu_pkg::OFF_CTRL) begin
      prdata = 32'(ctrl_r);
    end else if (paddr == asu_pkg::OFF_STAT1) begin
      prdata = 32'(stat_r);
    end else if (paddr == asu_pkg::OFF_STAT2) begin
      prdata[asu_pkg::RAF_POS] = (rx_state_r == asu_pkg::RX_FRAME);
    end else if (paddr == asu_pkg::OFF_DATA) begin
      prdata[7:0]              = rx_buf_r;
      prdata[asu_pkg::RX9_POS] = rx9_r;
      prdata[asu_pkg::TX9_POS] = tx9_r;
    end else if (paddr == asu_pkg::OFF_BAUD) begin
      prdata = 32'(baud_r);
    end else begin
      hit = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r  <= asu_pkg::asu_cfg_s'(asu_pkg::CFG_RST);
      baud_r <= asu_pkg::BAUD_RST;
    end else if (wr && paddr == asu_pkg::OFF_CFG) begin
      cfg_r <= asu_pkg::asu_cfg_s'(pwdata[3:0]);
    end else if (wr && paddr == asu_pkg::OFF_BAUD) begin
      baud_r <= pwdata[12:0];
    end
  end

  // hardware wake clears sleep; a write in the same cycle loses to it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= asu_pkg::asu_ctrl_s'(asu_pkg::CTRL_RST);
    end else begin
      if (ctrl_wr) begin
        ctrl_r <= asu_pkg::asu_ctrl_s'(pwdata[7:0]);
      end
      if (wake) begin
        ctrl_r.rx_wakeup_sleep <= 1'b0;
      end
    end
  end

  // ==========================================================
  // status flags: set wins over every clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed_r <= 8'h00;
    end else if (data_rd || data_wr) begin
      armed_r <= 8'h00;
    end else if (stat_rd) begin
      armed_r <= stat_r;
    end
  end

  always_comb begin
    clr_vec = (data_rd || data_wr) ? armed_r : 8'h00;
    if (stat_rd) begin
      clr_vec[0] = 1'b1;
    end
    if (data_wr) begin
      clr_vec[7] = 1'b1;
    end
    if (ld_brk || ld_pre || ld_dat) begin
      clr_vec[6] = 1'b1;
    end
    set_vec = {ld_dat, tx_done, rx_full_flag_ev, idle_det & msg_seen_r & ~ctrl_r.rx_wakeup_sleep,
               ovr_ev, rx_full_flag_ev & (noisy_r | bit_noisy), rx_full_flag_ev & ~bitval,
               rx_full_flag_ev & cfg_r.parity_en
                       & (rx_msb != calc_par(rx_sh_r, cfg_r.nine_bit, cfg_r.parity_odd))};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_r <= asu_pkg::asu_stat_s'(asu_pkg::STAT_RST);
    end else begin
      stat_r <= asu_pkg::asu_stat_s'((stat_r & ~clr_vec) | set_vec);
    end
  end

  // ==========================================================
  // interrupt request
  always_comb begin
    irq = (ctrl_r.tx_empty_irq_enable & stat_r.tx_buffer_empty_flag)
        | (ctrl_r.tx_done_irq_enable & stat_r.tx_complete_flag)
        | (~ctrl_r.rx_wakeup_sleep & ctrl_r.rx_irq_enable
           & (stat_r.rx_full_flag | stat_r.overrun_flag))
        | (~ctrl_r.rx_wakeup_sleep & ctrl_r.quiet_line_irq_enable
           & stat_r.idle_line_flag);
  end

  // ==========================================================
  // transmitter
  assign tx_bound = tick & (tx_ph_r == asu_pkg::PH_LAST);
  assign tx_free  = tx_bound & ((tx_state_r == asu_pkg::TX_IDLE) || (tx_cnt_r == 4'h1));
  // break outranks preamble, preamble outranks data
  assign ld_brk   = tx_free & ctrl_r.tx_enable & (brk_pend_r | ctrl_r.break_send);
  assign ld_pre   = tx_free & ctrl_r.tx_enable & ~ld_brk & pre_pend_r;
  assign ld_dat   = tx_free & ctrl_r.tx_enable & ~ld_brk & ~pre_pend_r & tx_full_r;
  assign tx_done  = tx_bound & (tx_state_r == asu_pkg::TX_SHIFT) & (tx_cnt_r == 4'h1)
                  & ~ld_brk & ~ld_pre & ~ld_dat;

  always_comb begin
    tx_word = {tx9_r, tx_buf_r};
    if (cfg_r.parity_en && cfg_r.nine_bit) begin
      tx_word[8] = calc_par(tx_word, 1'b1, cfg_r.parity_odd);
    end else if (cfg_r.parity_en) begin
      tx_word[7] = calc_par(tx_word, 1'b0, cfg_r.parity_odd);
    end
    if (!cfg_r.nine_bit) begin
      tx_word[8] = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      te_prev_r  <= 1'b0;
      pre_pend_r <= 1'b0;
      brk_pend_r <= 1'b0;
    end else begin
      te_prev_r <= ctrl_r.tx_enable;
      if (ctrl_r.tx_enable && !te_prev_r) begin
        pre_pend_r <= 1'b1;
      end else if (ld_pre) begin
        pre_pend_r <= 1'b0;
      end
      if (ctrl_wr && pwdata[asu_pkg::SBK_POS]) begin
        brk_pend_r <= 1'b1;
      end else if (ld_brk) begin
        brk_pend_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_buf_r  <= 8'h00;
      tx9_r     <= 1'b0;
      tx_full_r <= 1'b0;
    end else if (data_wr) begin
      tx_buf_r  <= pwdata[7:0];
      tx9_r     <= pwdata[asu_pkg::TX9_POS];
      tx_full_r <= 1'b1;
    end else if (ld_dat) begin
      tx_full_r <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_state_r <= asu_pkg::TX_IDLE;
      tx_sh_r    <= 11'h7ff;
      tx_cnt_r   <= 4'h0;
      tx_ph_r    <= 4'h0;
      txd        <= 1'b1;
    end else begin
      if (tick) begin
        tx_ph_r <= tx_ph_r + 4'h1;
      end
      txd <= (tx_state_r == asu_pkg::TX_SHIFT) ? tx_sh_r[0] : 1'b1;
      if (ld_brk) begin
        tx_state_r <= asu_pkg::TX_SHIFT;
        tx_sh_r    <= 11'h000;
        tx_cnt_r   <= flen;
      end else if (ld_pre) begin
        tx_state_r <= asu_pkg::TX_SHIFT;
        tx_sh_r    <= 11'h7ff;
        tx_cnt_r   <= flen;
      end else if (ld_dat) begin
        tx_state_r <= asu_pkg::TX_SHIFT;
        tx_sh_r    <= {1'b1, tx_word, 1'b0};
        tx_cnt_r   <= flen;
      end else if (tx_done) begin
        tx_state_r <= asu_pkg::TX_IDLE;
      end else if (tx_bound && tx_state_r == asu_pkg::TX_SHIFT) begin
        tx_sh_r  <= {1'b1, tx_sh_r[10:1]};
        tx_cnt_r <= tx_cnt_r - 4'h1;
      end
    end
  end

  // ==========================================================
  // receiver: majority of three mid-bit samples
  assign bitval    = (s1_r & s2_r) | (s1_r & rxd) | (s2_r & rxd);
  assign bit_noisy = ~((s1_r == s2_r) && (s2_r == rxd));
  assign rx_fin    = (rx_state_r == asu_pkg::RX_FRAME) & tick & (rx_ph_r == asu_pkg::PH_S3)
                   & (rx_idx_r == flen - 4'h1);
  assign rx_msb    = cfg_r.nine_bit ? rx_sh_r[8] : rx_sh_r[7];
  assign idle_det  = (rx_state_r == asu_pkg::RX_IDLE) & tick & (rx_ph_r == asu_pkg::PH_LAST)
                   & rxd & (idle_cnt_r == flen - 4'h1);
  // sleeping receiver only looks for its wake condition
  assign wake      = ctrl_r.rx_wakeup_sleep & ((cfg_r.wake_by_addr & rx_fin & rx_msb)
                   | (~cfg_r.wake_by_addr & idle_det));
  assign take_char = rx_fin & (~ctrl_r.rx_wakeup_sleep | wake);
  assign rx_full_flag_ev   = take_char & ~stat_r.rx_full_flag;
  assign ovr_ev    = take_char & stat_r.rx_full_flag;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_state_r <= asu_pkg::RX_IDLE;
      rx_ph_r    <= 4'h0;
      rx_idx_r   <= 4'h0;
      rx_sh_r    <= 9'h000;
      s1_r       <= 1'b1;
      s2_r       <= 1'b1;
      noisy_r    <= 1'b0;
      rxd_prev_r <= 1'b1;
    end else begin
      rxd_prev_r <= rxd;
      if (!ctrl_r.rx_enable) begin
        rx_state_r <= asu_pkg::RX_IDLE;
      end else if (rx_state_r == asu_pkg::RX_IDLE && rxd_prev_r && !rxd) begin
        rx_state_r <= asu_pkg::RX_FRAME;
        rx_ph_r    <= 4'h0;
        rx_idx_r   <= 4'h0;
        noisy_r    <= 1'b0;
      end else if (tick) begin
        rx_ph_r <= rx_ph_r + 4'h1;
        if (rx_ph_r == asu_pkg::PH_S1) begin
          s1_r <= rxd;
        end
        if (rx_ph_r == asu_pkg::PH_S2) begin
          s2_r <= rxd;
        end
        if (rx_state_r == asu_pkg::RX_FRAME && rx_ph_r == asu_pkg::PH_S3) begin
          rx_idx_r <= rx_idx_r + 4'h1;
          noisy_r  <= noisy_r | bit_noisy;
          if (rx_idx_r == 4'h0 && bitval) begin
            rx_state_r <= asu_pkg::RX_IDLE;
          end else if (rx_fin) begin
            rx_state_r <= asu_pkg::RX_IDLE;
          end else if (rx_idx_r != 4'h0) begin
            rx_sh_r[rx_idx_r - 4'h1] <= bitval;
          end
        end
      end
    end
  end

  // noise seen on the stop bit itself still counts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_buf_r <= 8'h00;
      rx9_r    <= 1'b0;
    end else if (rx_full_flag_ev) begin
      rx_buf_r <= rx_sh_r[7:0];
      rx9_r    <= cfg_r.nine_bit & rx_sh_r[8];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_cnt_r <= 4'h0;
      msg_seen_r <= 1'b0;
    end else begin
      if (!rxd || rx_state_r == asu_pkg::RX_FRAME) begin
        idle_cnt_r <= 4'h0;
      end else if (idle_det) begin
        idle_cnt_r <= 4'h0;
      end else if (tick && rx_ph_r == asu_pkg::PH_LAST) begin
        idle_cnt_r <= idle_cnt_r + 4'h1;
      end
      if (rx_fin) begin
        msg_seen_r <= 1'b1;
      end else if (idle_det) begin
        msg_seen_r <= 1'b0;
      end
    end
  end

endmodule

// ### verification/asu_serial_assertions.sv
// port-level checks of the async serial unit, bound to every asu_serial
// assumes divisor 0 while the transmitter is first enabled; control is shadowed from apb writes
`timescale 1ns/10ps
module asu_serial_assertions (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic [7:0]  paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        rxd,
  input wire logic        txd,
  input wire logic        irq
);
  asu_pkg::asu_ctrl_s ctrl_sh;
  logic [7:0]         te_cnt;
  logic               wr_ctrl;
  logic               rd_st1;
  logic               rd_st2;

  // ==========================================================
  // helper logic
  assign wr_ctrl = psel && penable && pwrite && paddr == asu_pkg::OFF_CTRL;
  assign rd_st1  = psel && penable && !pwrite && paddr == asu_pkg::OFF_STAT1;
  assign rd_st2  = psel && penable && !pwrite && paddr == asu_pkg::OFF_STAT2;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_sh <= asu_pkg::asu_ctrl_s'(asu_pkg::CTRL_RST);
    end else if (wr_ctrl) begin
      ctrl_sh <= asu_pkg::asu_ctrl_s'(pwdata[7:0]);
    end
  end

  // saturating count since the transmitter was switched on
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      te_cnt <= 8'hff;
    end else if (wr_ctrl && pwdata[3] && !ctrl_sh.tx_enable) begin
      te_cnt <= 8'h00;
    end else if (te_cnt != 8'hff) begin
      te_cnt <= te_cnt + 8'h01;
    end
  end

  // ==========================================================
  // properties
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_st1_read;
    rd_st1;
  endsequence
  sequence s_rx_seen;
    rd_st1 && (prdata[5] || prdata[3]);
  endsequence

  a_preamble_high: assert property (te_cnt < 8'h96 && !ctrl_sh.break_send |-> txd)
    else $error("transmit line low during preamble");
  a_rx_off_quiet: assert property (rd_st2 && !ctrl_sh.rx_enable |-> !prdata[asu_pkg::RAF_POS])
    else $error("receiver active while disabled");
  a_sleep_no_irq: assert property (ctrl_sh.rx_wakeup_sleep && !ctrl_sh.tx_empty_irq_enable
    && !ctrl_sh.tx_done_irq_enable |-> !irq) else $error("receiver request while asleep");
  a_irq_needs_enable: assert property (ctrl_sh[7:4] == 4'h0 |-> !irq)
    else $error("request with every enable clear");
  a_tx_empty_irq: assert property (rd_st1 && prdata[7] && ctrl_sh.tx_empty_irq_enable |-> irq)
    else $error("no request for empty buffer");
  a_rx_full_irq: assert property (s_rx_seen ##0 (ctrl_sh.rx_irq_enable
    && !ctrl_sh.rx_wakeup_sleep) |-> irq) else $error("no request for received data");
  a_parity_read_clear: assert property (s_st1_read ##3 s_st1_read |-> !prdata[0])
    else $error("parity flag survived status read");
  a_data_port_ok: assert property (psel && penable && paddr == asu_pkg::OFF_DATA
    |-> pready && !pslverr) else $error("data port access refused");
endmodule

bind asu_serial asu_serial_assertions u_chk (.pclk(pclk), .presetn(presetn), .paddr(paddr),
  .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .rxd(rxd), .txd(txd), .irq(irq));

// ### verification/asu_remote_end.sv
// remote serial end: drives the receive line, decodes frames on the transmit line
// assumes 16 pclk per bit (divisor 0); the line idles high between frames
`timescale 1ns/10ps
module asu_remote_end (
  input  wire logic pclk,
  input  wire logic txd,
  output logic      rxd
);
  int          nd;
  int          got_n;
  logic [10:0] got_r;
  time         t_fall;

  initial begin
    nd    = 8;
    got_n = 0;
    got_r = '0;
    rxd   = 1'b1;
  end

  // start, n data lsb first, stop; glitch flips one middle sample of the first data bit
  task automatic send(input logic [8:0] d, input int n, input logic stop, input logic glitch);
    logic b;
    for (int i = 0; i < n + 2; i++) begin
      b = (i == 0) ? 1'b0 : (i == n + 1) ? stop : d[i - 1];
      for (int k = 0; k < 16; k++) begin
        @(posedge pclk);
        rxd <= (glitch && i == 1 && k == 8) ? ~b : b;
      end
    end
    @(posedge pclk);
    rxd <= 1'b1;
  endtask

  // stops sampling in mid stop bit so a chained start edge is not missed
  always begin
    @(negedge txd);
    t_fall = $time;
    repeat (8) @(posedge pclk);
    for (int i = 0; i < nd + 2; i++) begin
      got_r[i] = txd;
      if (i < nd + 1) repeat (16) @(posedge pclk);
    end
    got_n++;
  end
endmodule

// ### verification/async_serial_ctrl_status_bench.sv
// self-checking bench of the async serial unit over apb
// assumes the remote end model and the checker are compiled before it
`timescale 1ns/10ps
module async_serial_ctrl_status_bench;
  logic        pclk, presetn, psel, penable, pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, rxd, txd, irq, err;
  int          failures, samples_checked;
  time         t0;

  asu_serial uut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rxd(rxd), .txd(txd), .irq(irq));
  asu_remote_end rem (.pclk(pclk), .txd(txd), .rxd(rxd));

  always #5 pclk = ~pclk;

  // ==========================================================
  // bus, compare and closing tasks
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      failures++;
      end_sim();
    end
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_min(input int got, input int lo);
    samples_checked++;
    if (got < lo) begin
      failures++;
      $display("MISMATCH %0t count %0d below %0d", $time, got, lo);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(a, 1'b0, 32'h0);
    chk(rd & m, e);
  endtask

  task automatic wait_got(input int n);
    int k;
    k = 0;
    while (rem.got_n < n && k < 5000) begin
      @(posedge pclk);
      k++;
    end
    if (k >= 5000) begin
      failures++;
      end_sim();
    end
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset();
    chk({31'h0, irq}, 32'h0);
    rd_chk(asu_pkg::OFF_STAT1, 32'hff, {24'h0, asu_pkg::STAT_RST});
    rd_chk(asu_pkg::OFF_CTRL, 32'hff, {24'h0, asu_pkg::CTRL_RST});
    rd_chk(8'h20, 32'hffffffff, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(asu_pkg::OFF_BAUD, 1'b1, 32'h0);
    // the old divisor count must run out before ticks come every clock
    repeat (60) @(posedge pclk);
  endtask

  task automatic t_tx();
    int n;
    n = rem.got_n;
    apb(asu_pkg::OFF_CTRL, 1'b1, 32'h88);
    t0 = $time;
    apb(asu_pkg::OFF_DATA, 1'b1, 32'ha5);
    repeat (20) @(posedge pclk);
    rd_chk(asu_pkg::OFF_STAT1, 32'hc0, 32'h0);
    wait_got(n + 1);
    chk_min(int'((rem.t_fall - t0) / 10), 160);
    chk({22'h0, rem.got_r[9:0]}, {22'h0, 1'b1, 8'ha5, 1'b0});
    repeat (40) @(posedge pclk);
    rd_chk(asu_pkg::OFF_STAT1, 32'hc0, 32'hc0);
    chk({31'h0, irq}, 32'h1);
    rem.nd = 9;
    apb(asu_pkg::OFF_CFG, 1'b1, 32'h8);
    apb(asu_pkg::OFF_DATA, 1'b1, 32'h413c);
    wait_got(n + 2);
    chk({21'h0, rem.got_r}, {21'h0, 1'b1, 9'h13c, 1'b0});
    rd_chk(asu_pkg::OFF_DATA, 32'h4000, 32'h4000);
    repeat (40) @(posedge pclk);
    rem.nd = 8;
    apb(asu_pkg::OFF_CFG, 1'b1, 32'h0);
  endtask

  task automatic t_break();
    int k;
    apb(asu_pkg::OFF_CTRL, 1'b1, 32'h09);
    apb(asu_pkg::OFF_CTRL, 1'b1, 32'h08);
    k = 0;
    while (txd !== 1'b0 && k < 100) begin
      @(posedge pclk);
      k++;
    end
    k = 0;
    while (txd === 1'b0 && k < 1000) begin
      @(posedge pclk);
      k++;
    end
    chk_min(k, 160);
    repeat (200) @(posedge pclk);
  endtask

  task automatic t_rx();
    apb(asu_pkg::OFF_CTRL, 1'b1, 32'h24);
    fork
      rem.send(9'h5a, 8, 1'b1, 1'b0);
      begin
        repeat (60) @(posedge pclk);
        rd_chk(asu_pkg::OFF_STAT2, 32'h1, 32'h1);
      end
    join
    repeat (20) @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
    rd_chk(asu_pkg::OFF_STAT1, 32'h20, 32'h20);
    rd_chk(asu_pkg::OFF_DATA, 32'hff, 32'h5a);
    rd_chk(asu_pkg::OFF_STAT1, 32'h20, 32'h0);
    rd_chk(asu_pkg::OFF_STAT2, 32'h1, 32'h0);
    repeat (200) @(posedge pclk);
    rd_chk(asu_pkg::OFF_STAT1, 32'h10, 32'h10);
    rem.send(9'h11, 8, 1'b1, 1'b0);
    rem.send(9'h22, 8, 1'b1, 1'b0);
    repeat (20) @(posedge pclk);
    rd_chk(asu_pkg::OFF_STAT1, 32'h28, 32'h28);
    rd_chk(asu_pkg::OFF_DATA, 32'hff, 32'h11);
    rd_chk(asu_pkg::OFF_STAT1, 32'h08, 32'h0);
  endtask

  task automatic t_err();
    rem.send(9'h33, 8, 1'b0, 1'b0);
    repeat (40) @(posedge pclk);
    rd_chk(asu_pkg::OFF_STAT1, 32'h02, 32'h02);
    rd_chk(asu_pkg::OFF_DATA, 32'hff, 32'h33);
    rem.send(9'h44, 8, 1'b1, 1'b1);
    repeat (20) @(posedge pclk);
    rd_chk(asu_pkg::OFF_STAT1, 32'h06, 32'h04);
    rd_chk(asu_pkg::OFF_DATA, 32'hff, 32'h44);
    apb(asu_pkg::OFF_CFG, 1'b1, 32'h4);
    rem.send(9'h01, 8, 1'b1, 1'b0);
    repeat (20) @(posedge pclk);
    rd_chk(asu_pkg::OFF_STAT1, 32'h01, 32'h01);
    rd_chk(asu_pkg::OFF_STAT1, 32'h01, 32'h0);
    rd_chk(asu_pkg::OFF_DATA, 32'h7f, 32'h01);
  endtask

  task automatic t_sleep();
    apb(asu_pkg::OFF_CFG, 1'b1, 32'h1);
    apb(asu_pkg::OFF_CTRL, 1'b1, 32'h26);
    rem.send(9'h12, 8, 1'b1, 1'b0);
    repeat (20) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    rd_chk(asu_pkg::OFF_STAT1, 32'h20, 32'h0);
    // receive request enable off, so a wake shows no request
    apb(asu_pkg::OFF_CTRL, 1'b1, 32'h06);
    rem.send(9'h92, 8, 1'b1, 1'b0);
    repeat (20) @(posedge pclk);
    rd_chk(asu_pkg::OFF_CTRL, 32'h02, 32'h0);
    rd_chk(asu_pkg::OFF_STAT1, 32'h20, 32'h20);
    rd_chk(asu_pkg::OFF_DATA, 32'hff, 32'h92);
    apb(asu_pkg::OFF_CTRL, 1'b1, 32'h20);
    rem.send(9'h34, 8, 1'b1, 1'b0);
    repeat (20) @(posedge pclk);
    rd_chk(asu_pkg::OFF_STAT1, 32'h20, 32'h0);
    rd_chk(asu_pkg::OFF_STAT2, 32'h1, 32'h0);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    failures        = 0;
    samples_checked = 0;
    pclk            = 1'b0;
    presetn         = 1'b0;
    psel            = 1'b0;
    penable         = 1'b0;
    pwrite          = 1'b0;
    paddr           = 8'h00;
    pwdata          = 32'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_tx();
    t_break();
    t_rx();
    t_err();
    t_sleep();
    end_sim();
  end
endmodule
